//--- src/rsi_pkg.sv
// shared constants, operand carriers and state codes for the hazard interlock
package rsi_pkg;

    // ------------------------------------------------------------------
    // widths
    // ------------------------------------------------------------------
    localparam int unsigned DATA_W  = 16;
    localparam int unsigned ADDR_W  = 8;
    localparam int unsigned IDX_W   = 4;
    localparam int unsigned PAGE_W  = 8;
    localparam int unsigned PSA_W   = 23;
    localparam int unsigned NUM_WREG = 8;

    // ------------------------------------------------------------------
    // register map (word addresses on the plain port)
    // ------------------------------------------------------------------
    localparam logic [ADDR_W-1:0] WREG_BASE_ADDR = 8'h00;
    localparam logic [ADDR_W-1:0] WREG_LAST_ADDR = 8'h07;
    localparam logic [ADDR_W-1:0] CTRL_ADDR      = 8'h08;
    localparam logic [ADDR_W-1:0] STATUS_ADDR    = 8'h09;

    // control register fields and reset value
    localparam int unsigned CTRL_WIN_EN_BIT = 0;
    localparam int unsigned CTRL_PAGE_LSB   = 8;
    localparam logic [DATA_W-1:0] CTRL_RESET = 16'h0000;
    localparam logic [DATA_W-1:0] WREG_RESET = 16'h0000;
    localparam logic [DATA_W-1:0] CNT_RESET  = 16'h0000;
    localparam logic [DATA_W-1:0] READ_ZERO  = 16'h0000;

    // effective address bit that selects the upper half (program window)
    localparam int unsigned EA_WIN_BIT = 15;

    // stack pointer lives in working register 15
    localparam logic [IDX_W-1:0] STACK_POINTER_REG_IDX = 4'hf;

    // ------------------------------------------------------------------
    // operand modes and instruction classes
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        MODE_DIRECT  = 2'h0,
        MODE_IND     = 2'h1,
        MODE_IND_MOD = 2'h2,
        MODE_NONE    = 2'h3
    } rsi_mode_t;

    typedef enum logic [2:0] {
        CLS_ALU   = 3'h0,
        CLS_CALL  = 3'h1,
        CLS_RET   = 3'h2,
        CLS_RETURN_WITH_LITERAL = 3'h3,
        CLS_JUMP  = 3'h4
    } rsi_cls_t;

    // executing instruction as seen by the interlock
    typedef struct packed {
        rsi_cls_t          cls;
        logic [IDX_W-1:0]  dst_idx;
        rsi_mode_t         dst_mode;
        logic              dst_mapped;
        logic [IDX_W-1:0]  src_idx;
        rsi_mode_t         src_mode;
    } rsi_exec_t;

    // prefetched instruction source side
    typedef struct packed {
        logic [IDX_W-1:0]  src_idx;
        rsi_mode_t         src_mode;
        logic [DATA_W-1:0] effective_address;
    } rsi_pref_t;

    // core-side working register write port
    typedef struct packed {
        logic              en;
        logic [IDX_W-1:0]  idx;
        logic [DATA_W-1:0] data;
    } rsi_wr_t;

    // ------------------------------------------------------------------
    // sequencer states, one-hot
    // ------------------------------------------------------------------
    typedef enum logic [4:0] {
        ST_EXEC  = 5'h01,
        ST_STALL = 5'h02,
        ST_WIN_A = 5'h04,
        ST_WIN_B = 5'h08,
        ST_EXC   = 5'h10
    } rsi_state_t;

endpackage

//--- src/rsi_interlock.sv
// read-after-write interlock with stall, window-read and exception sequencing
//
// Function
// [RULE1] hazard inserts exactly one wait cycle
// [RULE2] stall belongs to next instruction, precedes it
// [RULE3] pending register write completes during stall
// [RULE4] no data-space address during stall
// [RULE5] program counter holds during stall
// [RULE6] no instruction fetch during stall
// [RULE7] interrupt on first instruction drops stall
// [RULE8] interrupt on second: finish stall, instruction
// [RULE9] stall absorbed into normal exception entry
// [RULE10] calls write stack pointer, may stall
// [RULE11] returns never cause a stall
// [RULE12] return with literal is a hazard source
// [RULE13] jumps and branches never cause a stall
// [RULE14] repeat loop compares instruction with itself
// [RULE15] stalls leave repeat counting unchanged
// [RULE16] window hit redirects read to program space
// [RULE17] order: stall, window reads, then execute
// [RULE18] indirect window read adds two cycles
// [RULE19] written register used for address stalls
// [RULE20] unchanged destination register causes no stall
// [RULE21] direct source read causes no stall
// [RULE22] check every cycle, destination against source
`timescale 1ns/1ps
`default_nettype none

module rsi_interlock
    import rsi_pkg::*;
(
    input  wire logic                ref_clk_in,
    input  wire logic                rst_n_in,
    // register port
    input  wire logic [ADDR_W-1:0]   reg_addr_in,
    input  wire logic [DATA_W-1:0]   reg_wdata_in,
    input  wire logic                reg_wr_in,
    input  wire logic                reg_rd_in,
    output logic      [DATA_W-1:0]   reg_rdata_out,
    // decoder side
    input  wire rsi_exec_t           exec_info_in,
    input  wire rsi_pref_t           pref_info_in,
    input  wire logic                insn_last_in,
    input  wire logic                repeat_active_in,
    input  wire rsi_wr_t             wreg_wr_in,
    // exception sequencer side
    input  wire logic                irq_req_in,
    output logic                     exc_entry_out,
    // address generator and fetch control
    output logic                     stall_out,
    output logic                     pc_hold_out,
    output logic                     fetch_inhibit_out,
    output logic                     ds_addr_en_out,
    output logic                     window_read_out,
    output logic      [PSA_W-1:0]    pspace_addr_out,
    output logic                     repeat_advance_out
);

    // ------------------------------------------------------------------
    // reset release
    // ------------------------------------------------------------------
    logic rst_meta_q;
    logic rst_n_q;

    // two stages so the release never lands near a clock edge
    always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            rst_meta_q <= 1'b0;
            rst_n_q    <= 1'b0;
        end else begin
            rst_meta_q <= 1'b1;
            rst_n_q    <= rst_meta_q;
        end
    end

    // ------------------------------------------------------------------
    // hazard decode
    // ------------------------------------------------------------------
    // true when the executing instruction's write changes the register
    // that the next source read turns into an effective address
    function automatic logic raw_hazard(input rsi_exec_t e,
                                        input logic [IDX_W-1:0] s_idx,
                                        input rsi_mode_t s_mode);
        logic             modifies;
        logic [IDX_W-1:0] d_idx;
        modifies = 1'b0;
        d_idx    = e.dst_idx;
        unique case (e.cls)
            CLS_CALL: begin
                d_idx    = STACK_POINTER_REG_IDX; // [RULE10]
                modifies = 1'b1;
            end
            CLS_RET, CLS_JUMP: begin
                modifies = 1'b0;                  // [RULE11] [RULE13]
            end
            CLS_ALU, CLS_RETURN_WITH_LITERAL: begin
                // direct and post-modified writes change the register; a
                // plain indirect write only does so when it maps onto it
                modifies = (e.dst_mode == MODE_DIRECT) || (e.dst_mode == MODE_IND_MOD) ||
                           ((e.dst_mode == MODE_IND) && e.dst_mapped); // [RULE12] [RULE20]
            end
            default: modifies = 1'b0;
        endcase
        return modifies && (d_idx == s_idx) &&
               ((s_mode == MODE_IND) || (s_mode == MODE_IND_MOD)); // [RULE19] [RULE21]
    endfunction

    // ------------------------------------------------------------------
    // registers
    // ------------------------------------------------------------------
    logic [DATA_W-1:0] wreg_q [NUM_WREG];
    logic [DATA_W-1:0] ctrl_q;
    logic [DATA_W-1:0] stall_cnt_q;
    rsi_state_t        state_q;
    rsi_state_t        state_d;
    logic              irq_pend_q;
    logic              win_pend_q;
    logic [DATA_W-1:0] win_ea_q;

    logic              win_en;
    logic [PAGE_W-1:0] win_page;
    assign win_en   = ctrl_q[CTRL_WIN_EN_BIT];
    assign win_page = ctrl_q[CTRL_PAGE_LSB +: PAGE_W];

    // in a repeat loop the prefetched word is the executing one itself
    logic [IDX_W-1:0] chk_src_idx;
    rsi_mode_t        chk_src_mode;
    logic             hazard;
    logic             win_hit;
    logic             at_boundary;
    assign chk_src_idx  = repeat_active_in ? exec_info_in.src_idx  : pref_info_in.src_idx;  // [RULE14]
    assign chk_src_mode = repeat_active_in ? exec_info_in.src_mode : pref_info_in.src_mode; // [RULE14]
    assign hazard       = raw_hazard(exec_info_in, chk_src_idx, chk_src_mode); // [RULE22]
    assign at_boundary  = (state_q == ST_EXEC) && insn_last_in;

    // window reads only come from an indirect source landing in the upper half
    assign win_hit = win_en && pref_info_in.effective_address[EA_WIN_BIT] &&
                     ((pref_info_in.src_mode == MODE_IND) || (pref_info_in.src_mode == MODE_IND_MOD)); // [RULE16]

    // ------------------------------------------------------------------
    // sequencer next state
    // ------------------------------------------------------------------
    always_comb begin
        state_d = state_q;
        unique case (state_q)
            ST_EXEC: begin
                if (insn_last_in) begin
                    if (irq_pend_q) begin
                        state_d = ST_EXC;             // [RULE8] [RULE9]
                    end else if (irq_req_in) begin
                        state_d = ST_EXC;             // [RULE7]
                    end else if (hazard) begin
                        state_d = ST_STALL;           // [RULE1] [RULE2]
                    end else if (win_hit) begin
                        state_d = ST_WIN_A;           // [RULE18]
                    end
                end
            end
            ST_STALL: begin
                state_d = win_pend_q ? ST_WIN_A : ST_EXEC; // [RULE17]
            end
            ST_WIN_A: state_d = ST_WIN_B;             // [RULE18]
            ST_WIN_B: state_d = ST_EXEC;              // [RULE17]
            ST_EXC:   state_d = ST_EXEC;
            default:  state_d = ST_EXEC;
        endcase
    end

    // one-hot state register
    always_ff @(posedge ref_clk_in or negedge rst_n_q) begin
        if (!rst_n_q) begin
            state_q <= ST_EXEC;
        end else begin
            state_q <= state_d;
        end
    end

    // an interrupt seen while the second instruction waits is held until it ends
    always_ff @(posedge ref_clk_in or negedge rst_n_q) begin
        if (!rst_n_q) begin
            irq_pend_q <= 1'b0;
        end else if (state_q == ST_EXC) begin
            irq_pend_q <= 1'b0;
        end else if (irq_req_in && (state_q != ST_EXEC)) begin
            irq_pend_q <= 1'b1;                       // [RULE8]
        end
    end

    // window need and address are captured when the next instruction is chosen
    always_ff @(posedge ref_clk_in or negedge rst_n_q) begin
        if (!rst_n_q) begin
            win_pend_q <= 1'b0;
            win_ea_q   <= WREG_RESET;
        end else if (at_boundary) begin
            win_pend_q <= win_hit;
            win_ea_q   <= pref_info_in.effective_address;
        end
    end

    // ------------------------------------------------------------------
    // control outputs, registered from the next state
    // ------------------------------------------------------------------
    always_ff @(posedge ref_clk_in or negedge rst_n_q) begin
        if (!rst_n_q) begin
            stall_out         <= 1'b0;
            pc_hold_out       <= 1'b0;
            fetch_inhibit_out <= 1'b0;
            ds_addr_en_out    <= 1'b0;
            window_read_out   <= 1'b0;
            exc_entry_out     <= 1'b0;
        end else begin
            stall_out         <= (state_d == ST_STALL);                        // [RULE1]
            pc_hold_out       <= (state_d == ST_STALL) || (state_d == ST_WIN_A) ||
                                 (state_d == ST_WIN_B);                        // [RULE5]
            fetch_inhibit_out <= (state_d == ST_STALL) || (state_d == ST_WIN_A) ||
                                 (state_d == ST_WIN_B);                        // [RULE6]
            ds_addr_en_out    <= (state_d != ST_STALL) && (state_d != ST_EXC); // [RULE4]
            window_read_out   <= (state_d == ST_WIN_A) || (state_d == ST_WIN_B); // [RULE16]
            exc_entry_out     <= (state_d == ST_EXC);                          // [RULE9]
        end
    end

    // redirected read address: page above the low fifteen offset bits
    always_ff @(posedge ref_clk_in or negedge rst_n_q) begin
        if (!rst_n_q) begin
            pspace_addr_out <= '0;
        end else if ((state_d == ST_WIN_A) || (state_d == ST_WIN_B)) begin
            // at the deciding edge the captured address still holds the old one
            pspace_addr_out <= {win_page, at_boundary ? pref_info_in.effective_address[EA_WIN_BIT-1:0]
                                                      : win_ea_q[EA_WIN_BIT-1:0]}; // [RULE16]
        end
    end

    // loop count moves only on a finished execute cycle, never on a stall
    always_ff @(posedge ref_clk_in or negedge rst_n_q) begin
        if (!rst_n_q) begin
            repeat_advance_out <= 1'b0;
        end else begin
            repeat_advance_out <= at_boundary && repeat_active_in; // [RULE15]
        end
    end

    // ------------------------------------------------------------------
    // working registers and register port
    // ------------------------------------------------------------------
    logic core_wr_hit;
    logic bus_wr_wreg;
    assign core_wr_hit = wreg_wr_in.en && (wreg_wr_in.idx < IDX_W'(NUM_WREG));
    assign bus_wr_wreg = reg_wr_in && (reg_addr_in <= WREG_LAST_ADDR);

    // core write is never gated by the stall; it takes priority over software
    always_ff @(posedge ref_clk_in or negedge rst_n_q) begin
        if (!rst_n_q) begin
            for (int i = 0; i < NUM_WREG; i++) begin
                wreg_q[i] <= WREG_RESET;
            end
        end else if (core_wr_hit) begin
            wreg_q[wreg_wr_in.idx[2:0]] <= wreg_wr_in.data; // [RULE3]
        end else if (bus_wr_wreg) begin
            wreg_q[reg_addr_in[2:0]] <= reg_wdata_in;
        end
    end

    // window enable and page
    always_ff @(posedge ref_clk_in or negedge rst_n_q) begin
        if (!rst_n_q) begin
            ctrl_q <= CTRL_RESET;
        end else if (reg_wr_in && (reg_addr_in == CTRL_ADDR)) begin
            ctrl_q <= reg_wdata_in;
        end
    end

    // stall cycle counter; a write clears it, a stall in the same cycle still counts
    always_ff @(posedge ref_clk_in or negedge rst_n_q) begin
        if (!rst_n_q) begin
            stall_cnt_q <= CNT_RESET;
        end else if (state_q == ST_STALL) begin
            stall_cnt_q <= (reg_wr_in && (reg_addr_in == STATUS_ADDR)) ?
                           16'h0001 : DATA_W'(stall_cnt_q + 16'h0001);
        end else if (reg_wr_in && (reg_addr_in == STATUS_ADDR)) begin
            stall_cnt_q <= CNT_RESET;
        end
    end

    // read data in the cycle after the strobe; unmapped reads return zero
    always_ff @(posedge ref_clk_in or negedge rst_n_q) begin
        if (!rst_n_q) begin
            reg_rdata_out <= READ_ZERO;
        end else if (reg_rd_in) begin
            if (reg_addr_in <= WREG_LAST_ADDR) begin
                reg_rdata_out <= wreg_q[reg_addr_in[2:0]];
            end else if (reg_addr_in == CTRL_ADDR) begin
                reg_rdata_out <= ctrl_q;
            end else if (reg_addr_in == STATUS_ADDR) begin
                reg_rdata_out <= stall_cnt_q;
            end else begin
                reg_rdata_out <= READ_ZERO;
            end
        end else begin
            reg_rdata_out <= READ_ZERO;
        end
    end

    // ------------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge ref_clk_in);
    endclocking
    default disable iff (!rst_n_q);

    logic irq_ok;
    assign irq_ok = !irq_req_in && !irq_pend_q;

    stall_one_cycle_a: assert property (stall_out |=> !stall_out) // [RULE1]
        else $error("stall lasted more than one cycle");
    stall_no_addr_a: assert property (stall_out |-> !ds_addr_en_out ##1 !repeat_advance_out) // [RULE4] [RULE15]
        else $error("data space addressed during stall");
    stall_pc_hold_a: assert property (stall_out |-> pc_hold_out ##1 (pc_hold_out == window_read_out)) // [RULE5]
        else $error("program counter moved during stall");
    stall_no_fetch_a: assert property (stall_out |-> fetch_inhibit_out) // [RULE6]
        else $error("fetch started during stall");
    hazard_stalls_a: assert property (at_boundary && hazard && irq_ok |=> stall_out) // [RULE19]
        else $error("hazard did not stall");
    irq_first_a: assert property (at_boundary && irq_req_in && !irq_pend_q |=> exc_entry_out && !stall_out) // [RULE7]
        else $error("stall kept after interrupt on first instruction");
    irq_second_a: assert property (stall_out && irq_req_in |-> ##[2:8] exc_entry_out) // [RULE8]
        else $error("exception not taken after stalled instruction");
    call_sp_stall_a: assert property (at_boundary && irq_ok && (exec_info_in.cls == CLS_CALL) &&
                                      !repeat_active_in &&
                                      (pref_info_in.src_idx == STACK_POINTER_REG_IDX) &&
                                      (pref_info_in.src_mode == MODE_IND) |=> stall_out) // [RULE10]
        else $error("call did not stall a stack pointer read");
    ret_jump_free_a: assert property (at_boundary && ((exec_info_in.cls == CLS_RET) ||
                                      (exec_info_in.cls == CLS_JUMP)) |=> !stall_out) // [RULE13]
        else $error("stall after return or jump");
    direct_free_a: assert property (at_boundary && (chk_src_mode == MODE_DIRECT) |=> !stall_out) // [RULE21]
        else $error("stall on a direct source read");
    stall_then_win_a: assert property (stall_out && win_pend_q |=> window_read_out [*2] ##1 !window_read_out) // [RULE17]
        else $error("window cycles not after stall");
    core_write_a: assert property (stall_out && core_wr_hit |=>
                                   (wreg_q[$past(wreg_wr_in.idx[2:0])] == $past(wreg_wr_in.data))) // [RULE3]
        else $error("register write lost during stall");

    stall_seen_c: cover property (at_boundary && hazard ##1 stall_out ##1 !stall_out);
    stall_win_c: cover property (stall_out ##1 window_read_out ##1 window_read_out);
    stall_irq_c: cover property (stall_out && irq_req_in ##[1:6] exc_entry_out);
    repeat_stall_c: cover property (repeat_active_in && stall_out);

endmodule

`default_nettype wire

//--- bench/rsi_core_model.sv
// decoder-side partner model: presents executing and prefetched instructions
`timescale 1ns/1ps
`default_nettype none

module rsi_core_model
    import rsi_pkg::*;
(
    input  wire logic ref_clk_in,
    output var rsi_exec_t exec_info_out,
    output var rsi_pref_t pref_info_out,
    output logic      insn_last_out,
    output logic      repeat_active_out,
    output var rsi_wr_t wreg_wr_out,
    output logic      irq_req_out
);
    // idle: no instruction boundary, no write, no request
    initial begin
        exec_info_out     = '0;
        pref_info_out     = '0;
        insn_last_out     = 1'b0;
        repeat_active_out = 1'b0;
        wreg_wr_out       = '0;
        irq_req_out       = 1'b0;
    end

    // one instruction boundary; returns just after the deciding edge
    task automatic issue(input rsi_exec_t e, input rsi_pref_t p, input bit ir, late, rp, wr);
        @(posedge ref_clk_in);
        exec_info_out     <= e;
        pref_info_out     <= p;
        repeat_active_out <= rp;
        irq_req_out       <= ir;
        insn_last_out     <= 1'b1;
        @(posedge ref_clk_in);
        insn_last_out <= 1'b0;
        irq_req_out   <= late;
        // previous instruction's write lands while the stall runs
        wreg_wr_out   <= '{en: wr, idx: e.dst_idx, data: 16'hbeef};
    endtask

    // drop the late request and write after one cycle
    task automatic release_side();
        irq_req_out       <= 1'b0;
        wreg_wr_out.en    <= 1'b0;
        repeat_active_out <= 1'b0;
    endtask
endmodule

`default_nettype wire

//--- bench/tb_top.sv
// self-checking bench for the hazard interlock
`timescale 1ns/1ps
`default_nettype none

module tb_top
    import rsi_pkg::*;
;
    logic              ref_clk_in = 1'b0;
    logic              rst_n_in   = 1'b0;
    logic [ADDR_W-1:0] reg_addr   = 8'h00;
    logic [DATA_W-1:0] reg_wdata  = 16'h0000;
    logic              reg_wr     = 1'b0;
    logic              reg_rd     = 1'b0;
    logic [DATA_W-1:0] reg_rdata, rd_val;
    logic              exc, stall, pc_hold, fetch_inh, ds_en, win, rep_adv, insn_last, rep_act, irq;
    logic [PSA_W-1:0]  ps_addr;
    rsi_exec_t         exec_info;
    rsi_pref_t         pref_info;
    rsi_wr_t           wreg_wr;
    int                n_mismatch = 0, comparisons = 0, cycles = 0, n_stall = 0;

    always #12.5 ref_clk_in = ~ref_clk_in;

    rsi_interlock dut_u (.ref_clk_in(ref_clk_in), .rst_n_in(rst_n_in), .reg_addr_in(reg_addr),
        .reg_wdata_in(reg_wdata), .reg_wr_in(reg_wr), .reg_rd_in(reg_rd), .reg_rdata_out(reg_rdata),
        .exec_info_in(exec_info), .pref_info_in(pref_info), .insn_last_in(insn_last),
        .repeat_active_in(rep_act), .wreg_wr_in(wreg_wr), .irq_req_in(irq), .exc_entry_out(exc),
        .stall_out(stall), .pc_hold_out(pc_hold), .fetch_inhibit_out(fetch_inh), .ds_addr_en_out(ds_en),
        .window_read_out(win), .pspace_addr_out(ps_addr), .repeat_advance_out(rep_adv));

    rsi_core_model model_u (.ref_clk_in(ref_clk_in), .exec_info_out(exec_info), .pref_info_out(pref_info),
        .insn_last_out(insn_last), .repeat_active_out(rep_act), .wreg_wr_out(wreg_wr), .irq_req_out(irq));

    // ------------------------------------------------------------------
    // checks and bus tasks
    // ------------------------------------------------------------------
    task automatic chk_bit(logic got, logic exp);
        comparisons++;
        if (got !== exp) begin
            n_mismatch++;
            $display("BAD t=%0t got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic chk_val(logic [PSA_W-1:0] got, logic [PSA_W-1:0] exp);
        comparisons++;
        if (got !== exp) begin
            n_mismatch++;
            $display("BAD t=%0t got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic reg_write(logic [ADDR_W-1:0] a, logic [DATA_W-1:0] d);
        @(posedge ref_clk_in);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge ref_clk_in);
        reg_wr <= 1'b0;
    endtask

    // read data is only valid in the cycle after the strobe
    task automatic reg_read(logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d);
        @(posedge ref_clk_in);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge ref_clk_in);
        reg_rd <= 1'b0;
        #1 d = reg_rdata;
    endtask

    // one boundary, then four cycles of expected sequencer outputs
    task automatic run(rsi_cls_t c, rsi_mode_t dm, bit mp, logic [3:0] di, rsi_mode_t sm, logic [3:0] si,
                       logic [15:0] ea, bit ir, bit late, bit rp, bit wr, bit es, bit ew, bit ex);
        logic [3:0] st, wn, xc;
        st = {3'b000, es & ~ex};
        xc = {3'b000, ex};
        wn = (ew & ~ex) ? (es ? 4'b0110 : 4'b0011) : 4'b0000;
        n_stall = n_stall + int'(es & ~ex);
        model_u.issue('{c, di, dm, mp, si, sm}, '{si, rp ? MODE_DIRECT : sm, ea}, ir, late, rp, wr);
        for (int k = 0; k < 4; k++) begin
            #1;
            chk_bit(stall, st[k]);
            chk_bit(win, wn[k]);
            chk_bit(exc, xc[k]);
            chk_bit(pc_hold, st[k] | wn[k]);
            chk_bit(fetch_inh, st[k] | wn[k]);
            chk_bit(ds_en, ~(st[k] | xc[k]));
            chk_bit(rep_adv, (k == 0) & rp);
            if (wn[k]) chk_val(ps_addr, {8'haa, ea[14:0]});
            @(posedge ref_clk_in);
            if (k == 0) model_u.release_side();
        end
    endtask

    task automatic results();
        $display("counts: %0d comparisons, %0d mismatches", comparisons, n_mismatch);
        if (n_mismatch == 0 && comparisons > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    // hang guard, well above the roughly 160 cycles the tests need
    always @(posedge ref_clk_in) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            n_mismatch++;
            results();
        end
    end

    // ------------------------------------------------------------------
    // test sequence
    // ------------------------------------------------------------------
    initial begin
        repeat (5) @(posedge ref_clk_in);
        rst_n_in <= 1'b1;
        repeat (3) @(posedge ref_clk_in);
        for (int i = 0; i < 11; i++) begin
            reg_read(i[7:0], rd_val);
            chk_val(rd_val, '0);
        end
        reg_write(8'h03, 16'h1234);
        reg_read(8'h03, rd_val);
        chk_val(rd_val, 16'h1234);
        $display("test registers done");
        run(CLS_ALU, MODE_DIRECT, 0, 4'h2, MODE_IND, 4'h2, 16'h0100, 0, 0, 0, 1, 1, 0, 0);
        run(CLS_ALU, MODE_DIRECT, 0, 4'h2, MODE_IND_MOD, 4'h2, 16'h0100, 0, 0, 0, 0, 1, 0, 0);
        run(CLS_ALU, MODE_DIRECT, 0, 4'h2, MODE_DIRECT, 4'h2, 16'h0100, 0, 0, 0, 0, 0, 0, 0);
        run(CLS_ALU, MODE_IND, 0, 4'h2, MODE_IND, 4'h2, 16'h0100, 0, 0, 0, 0, 0, 0, 0);
        run(CLS_ALU, MODE_IND, 1, 4'h2, MODE_IND, 4'h2, 16'h0100, 0, 0, 0, 0, 1, 0, 0);
        run(CLS_ALU, MODE_IND_MOD, 0, 4'h2, MODE_DIRECT, 4'h2, 16'h0100, 0, 0, 0, 0, 0, 0, 0);
        run(CLS_ALU, MODE_IND_MOD, 0, 4'h2, MODE_IND_MOD, 4'h2, 16'h0100, 0, 0, 0, 0, 1, 0, 0);
        run(CLS_ALU, MODE_DIRECT, 0, 4'h2, MODE_IND, 4'h3, 16'h0100, 0, 0, 0, 0, 0, 0, 0);
        run(CLS_CALL, MODE_DIRECT, 0, 4'h0, MODE_IND, 4'hf, 16'h0100, 0, 0, 0, 0, 1, 0, 0);
        run(CLS_RET, MODE_DIRECT, 0, 4'h2, MODE_IND, 4'h2, 16'h0100, 0, 0, 0, 0, 0, 0, 0);
        run(CLS_RETURN_WITH_LITERAL, MODE_DIRECT, 0, 4'h2, MODE_IND, 4'h2, 16'h0100, 0, 0, 0, 0, 1, 0, 0);
        run(CLS_JUMP, MODE_DIRECT, 0, 4'h2, MODE_IND, 4'h2, 16'h0100, 0, 0, 0, 0, 0, 0, 0);
        run(CLS_ALU, MODE_DIRECT, 0, 4'h1, MODE_IND, 4'h1, 16'h0100, 0, 0, 1, 0, 1, 0, 0);
        reg_read(8'h02, rd_val);
        chk_val(rd_val, 16'hbeef);
        $display("test hazards done");
        reg_write(CTRL_ADDR, 16'haa01);
        run(CLS_ALU, MODE_DIRECT, 0, 4'h5, MODE_IND, 4'h6, 16'h8004, 0, 0, 0, 0, 0, 1, 0);
        chk_val(ps_addr, {8'haa, 15'h0004});
        run(CLS_ALU, MODE_DIRECT, 0, 4'h2, MODE_IND, 4'h2, 16'h8008, 0, 0, 0, 0, 1, 1, 0);
        run(CLS_ALU, MODE_DIRECT, 0, 4'h2, MODE_DIRECT, 4'h2, 16'h8000, 0, 0, 0, 0, 0, 0, 0);
        $display("test window done");
        run(CLS_ALU, MODE_DIRECT, 0, 4'h2, MODE_IND, 4'h2, 16'h0100, 1, 0, 0, 0, 1, 0, 1);
        run(CLS_ALU, MODE_DIRECT, 0, 4'h2, MODE_IND, 4'h2, 16'h0100, 0, 1, 0, 0, 1, 0, 0);
        run(CLS_ALU, MODE_DIRECT, 0, 4'h4, MODE_DIRECT, 4'h5, 16'h0100, 0, 0, 0, 0, 0, 0, 1);
        $display("test interrupts done");
        reg_read(STATUS_ADDR, rd_val);
        chk_val(rd_val, n_stall[15:0]);
        reg_write(STATUS_ADDR, 16'h0000);
        reg_read(STATUS_ADDR, rd_val);
        chk_val(rd_val, '0);
        $display("test stall count done");
        results();
    end
endmodule

`default_nettype wire
